// >>> design/tpc_top.sv
// Three-phase direct PWM stage with current offset and command registers
// What this block does
// [RULE1] Zero commands give 50 percent duty minus deadtime at the period's frequency.
// [RULE2] All three high-side outputs share one carrier and stay in phase.
// [RULE3] Low-side outputs are in phase, half a cycle from the high side.
// [RULE4] Each pair keeps a deadtime where neither output is on.
// [RULE5] Positive command lengthens high on-time, shortens low; negative reverses.
// [RULE6] Commands written together in one update reach the outputs together.
// [RULE7] Phase A and B readings are corrected by separate signed offsets.
// [RULE8] Offsets and readings are both scaled as 16-bit signed values.
// [RULE9] Phase angle below 128 advances positive, above 128 negative.
// [RULE10] One commutation cycle spans cycle size divided by divisor counts.
// [RULE11] Open-loop command closes only current loops; magnitude is percent of limit.
// [RULE12] Direct current magnitude comes from its own parameter.
// [RULE13] Signed command maps linearly to duty; full scale equals period count.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module tpc_top
	import tpc_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [W-1:0] phase_a_adc_i,
	input wire logic [W-1:0] phase_b_adc_i,
	input wire logic [W-1:0] feedback_count_i,
	output logic phase_a_high_side_out_o,
	output logic phase_a_low_side_out_o,
	output logic phase_b_high_side_out_o,
	output logic phase_b_low_side_out_o,
	output logic phase_c_high_side_out_o,
	output logic phase_c_low_side_out_o,
	output logic commutation_forward_o,
	output logic current_loops_closed_o
);
	logic [W-1:0] pwm_period_setting;
	logic [W-1:0] pwm_deadtime_setting;
	logic [W-1:0] cmd_shadow [3];
	logic [W-1:0] cmd_live [3];
	logic update_pending;
	logic [W-1:0] phase_a_current_offset;
	logic [W-1:0] phase_b_current_offset;
	logic [7:0] commutation_phase_angle;
	logic [W-1:0] commutation_cycle_size;
	logic [W-1:0] commutation_cycle_divisor;
	logic [W-1:0] output_current_limit;
	logic [W-1:0] direct_current_magnitude;
	logic [7:0] open_loop_percent;
	logic open_loop_en;
	logic [W-1:0] quad_current_cmd;
	logic [W-1:0] cycle_counts;
	logic [W-1:0] carrier;
	tpc_dir_t dir;
	logic [W-1:0] adc_a_s1, adc_a_s2, adc_b_s1, adc_b_s2, fb_s1, fb_s2;
	logic [W-1:0] phase_a_current_reading;
	logic [W-1:0] phase_b_current_reading;
	logic [W-1:0] rotor_position_count;
	logic [W-1:0] threshold [3];
	logic [2:0] leg_high;
	logic [2:0] leg_low;
	logic wb_req;
	logic wb_wr;
	logic [31:0] next_rdata;
	logic [W-1:0] wdat;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land at the edge where the master sees ack, not when the request is taken
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign wdat = wb_dat_i[W-1:0];

	// Two-stage capture of pin-level feedback
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adc_a_s1 <= '0;
			adc_a_s2 <= '0;
			adc_b_s1 <= '0;
			adc_b_s2 <= '0;
			fb_s1 <= '0;
			fb_s2 <= '0;
		end else begin
			adc_a_s1 <= phase_a_adc_i;
			adc_a_s2 <= adc_a_s1;
			adc_b_s1 <= phase_b_adc_i;
			adc_b_s2 <= adc_b_s1;
			fb_s1 <= feedback_count_i;
			fb_s2 <= fb_s1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rotor_position_count <= '0;
		end else begin
			rotor_position_count <= fb_s2;
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_period_setting <= TPC_PERIOD_RST;
			pwm_deadtime_setting <= TPC_DEADTIME_RST;
			phase_a_current_offset <= '0;
			phase_b_current_offset <= '0;
			commutation_phase_angle <= TPC_ANGLE_RST;
			commutation_cycle_size <= TPC_CYC_SIZE_RST;
			commutation_cycle_divisor <= TPC_CYC_DIV_RST;
			output_current_limit <= TPC_CUR_LIMIT_RST;
			direct_current_magnitude <= '0;
			open_loop_percent <= '0;
			open_loop_en <= 1'b0;
		end else if (wb_wr) begin
			unique case (wb_adr_i)
				TPC_REG_PERIOD: pwm_period_setting <= (wdat == '0) ? 16'h0001 : wdat;
				TPC_REG_DEADTIME: pwm_deadtime_setting <= wdat;
				TPC_REG_OFFSET_A: phase_a_current_offset <= wdat; // RULE7
				TPC_REG_OFFSET_B: phase_b_current_offset <= wdat; // RULE7
				TPC_REG_ANGLE: commutation_phase_angle <= wb_dat_i[7:0];
				TPC_REG_CYC_SIZE: commutation_cycle_size <= wdat;
				TPC_REG_CYC_DIV: commutation_cycle_divisor <= (wdat == '0) ? 16'h0001 : wdat;
				TPC_REG_CUR_LIMIT: output_current_limit <= wdat;
				TPC_REG_DIRECT: direct_current_magnitude <= wdat; // RULE12
				TPC_REG_OPEN_LOOP: begin
					open_loop_percent <= wb_dat_i[7:0];
					open_loop_en <= wb_dat_i[TPC_OPEN_LOOP_EN_BIT]; // RULE11
				end
				default: ;
			endcase
		end
	end

	// Command shadows; live copies load together at the carrier bottom
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 3; i++) begin
				cmd_shadow[i] <= '0;
				cmd_live[i] <= '0;
			end
			update_pending <= 1'b0;
		end else begin
			if (wb_wr && wb_adr_i == TPC_REG_CMD_A) cmd_shadow[0] <= wdat;
			if (wb_wr && wb_adr_i == TPC_REG_CMD_B) cmd_shadow[1] <= wdat;
			if (wb_wr && wb_adr_i == TPC_REG_CMD_C) cmd_shadow[2] <= wdat;
			if (dir == TPC_UP && carrier == '0 && update_pending) begin
				for (int i = 0; i < 3; i++) cmd_live[i] <= cmd_shadow[i]; // RULE6
			end
			if (wb_wr && wb_adr_i == TPC_REG_UPDATE && wb_dat_i[TPC_UPDATE_BIT]) begin
				update_pending <= 1'b1; // RULE6
			end else if (dir == TPC_UP && carrier == '0) begin
				update_pending <= 1'b0;
			end
		end
	end

	// Shared up/down carrier, period counts each way
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carrier <= '0;
			dir <= TPC_UP;
		end else if (dir == TPC_UP) begin
			if (carrier >= pwm_period_setting - 16'h0001) dir <= TPC_DOWN;
			carrier <= carrier + 16'h0001; // RULE1 RULE2
		end else begin
			if (carrier <= 16'h0001) dir <= TPC_UP;
			carrier <= carrier - 16'h0001; // RULE1 RULE2
		end
	end

	// Threshold = period/2 + cmd/2, clamped to 0..period
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_leg
			logic signed [W+1:0] t;
			always_comb begin
				t = $signed({2'b00, pwm_period_setting[W-1:1]})
					+ $signed({{2{cmd_live[g][W-1]}}, cmd_live[g]}) / 2; // RULE13 RULE5
				if (t < 0) threshold[g] = '0;
				else if (t > $signed({2'b00, pwm_period_setting})) threshold[g] = pwm_period_setting;
				else threshold[g] = t[W-1:0];
			end
			tpc_phase_leg #(.W(W)) u_leg (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.carrier_i(carrier),
				.threshold_i(threshold[g]),
				.deadtime_i(pwm_deadtime_setting),
				.high_o(leg_high[g]),
				.low_o(leg_low[g])
			); // RULE3 RULE4
		end
	endgenerate

	tpc_current_adjust #(.W(W)) u_adj_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i(adc_a_s2),
		.offset_i(phase_a_current_offset),
		.corrected_o(phase_a_current_reading)
	); // RULE7 RULE8
	tpc_current_adjust #(.W(W)) u_adj_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i(adc_b_s2),
		.offset_i(phase_b_current_offset),
		.corrected_o(phase_b_current_reading)
	); // RULE7 RULE8

	// Derived commutation and current-loop values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cycle_counts <= '0;
			quad_current_cmd <= '0;
			commutation_forward_o <= 1'b1;
			current_loops_closed_o <= 1'b0;
		end else begin
			cycle_counts <= commutation_cycle_size / commutation_cycle_divisor; // RULE10
			quad_current_cmd <= W'((32'(output_current_limit) * 32'(open_loop_percent)) / 100); // RULE11
			commutation_forward_o <= commutation_phase_angle < TPC_ANGLE_MID; // RULE9
			current_loops_closed_o <= open_loop_en; // RULE11
		end
	end

	// Outputs registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_a_high_side_out_o <= 1'b0;
			phase_a_low_side_out_o <= 1'b0;
			phase_b_high_side_out_o <= 1'b0;
			phase_b_low_side_out_o <= 1'b0;
			phase_c_high_side_out_o <= 1'b0;
			phase_c_low_side_out_o <= 1'b0;
		end else begin
			phase_a_high_side_out_o <= leg_high[0];
			phase_a_low_side_out_o <= leg_low[0];
			phase_b_high_side_out_o <= leg_high[1];
			phase_b_low_side_out_o <= leg_low[1];
			phase_c_high_side_out_o <= leg_high[2];
			phase_c_low_side_out_o <= leg_low[2];
		end
	end

	// Read mux; unmapped reads zero
	always_comb begin
		next_rdata = '0;
		unique case (wb_adr_i)
			TPC_REG_PERIOD: next_rdata[W-1:0] = pwm_period_setting;
			TPC_REG_DEADTIME: next_rdata[W-1:0] = pwm_deadtime_setting;
			TPC_REG_CMD_A: next_rdata[W-1:0] = cmd_shadow[0];
			TPC_REG_CMD_B: next_rdata[W-1:0] = cmd_shadow[1];
			TPC_REG_CMD_C: next_rdata[W-1:0] = cmd_shadow[2];
			TPC_REG_OFFSET_A: next_rdata[W-1:0] = phase_a_current_offset;
			TPC_REG_OFFSET_B: next_rdata[W-1:0] = phase_b_current_offset;
			TPC_REG_CUR_A: next_rdata[W-1:0] = phase_a_current_reading;
			TPC_REG_CUR_B: next_rdata[W-1:0] = phase_b_current_reading;
			TPC_REG_ANGLE: next_rdata[7:0] = commutation_phase_angle;
			TPC_REG_CYC_SIZE: next_rdata[W-1:0] = commutation_cycle_size;
			TPC_REG_CYC_DIV: next_rdata[W-1:0] = commutation_cycle_divisor;
			TPC_REG_CUR_LIMIT: next_rdata[W-1:0] = output_current_limit;
			TPC_REG_DIRECT: next_rdata[W-1:0] = direct_current_magnitude;
			TPC_REG_OPEN_LOOP: next_rdata = {15'h0000, open_loop_en, 8'h00, open_loop_percent};
			TPC_REG_QUAD_CMD: next_rdata[W-1:0] = quad_current_cmd;
			TPC_REG_POSITION: next_rdata = {cycle_counts, rotor_position_count};
			TPC_REG_STATUS: begin
				next_rdata[TPC_ST_DIR_BIT] = commutation_forward_o;
				next_rdata[TPC_ST_LOOP_BIT] = current_loops_closed_o;
				next_rdata[TPC_ST_PENDING_BIT] = update_pending;
			end
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : '0;
		end
	end

	direction_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$stable(commutation_phase_angle) && commutation_phase_angle > TPC_ANGLE_MID
		|=> !commutation_forward_o) else $error("angle above mid not negative"); // RULE9
	cmds_together_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(cmd_live[0]) |-> $past(dir == TPC_UP && carrier == '0 && update_pending))
		else $error("command loaded off the carrier bottom"); // RULE6
	zero_half_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_live[1] == '0 |-> threshold[1] == {1'b0, pwm_period_setting[W-1:1]})
		else $error("zero command not half duty"); // RULE1 RULE13
	legs_in_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cmd_live[0] == cmd_live[1] && $stable(cmd_live[0]) && $stable(cmd_live[1]))
		|=> leg_high[0] == leg_high[1]) else $error("high sides out of phase"); // RULE2
	ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
endmodule

// >>> design/tpc_pkg.sv
// Package of constants and types for the three-phase PWM current loop block
package tpc_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] TPC_REG_PERIOD = 8'h00;
	localparam logic [7:0] TPC_REG_DEADTIME = 8'h04;
	localparam logic [7:0] TPC_REG_CMD_A = 8'h08;
	localparam logic [7:0] TPC_REG_CMD_B = 8'h0c;
	localparam logic [7:0] TPC_REG_CMD_C = 8'h10;
	localparam logic [7:0] TPC_REG_UPDATE = 8'h14;
	localparam logic [7:0] TPC_REG_OFFSET_A = 8'h18;
	localparam logic [7:0] TPC_REG_OFFSET_B = 8'h1c;
	localparam logic [7:0] TPC_REG_CUR_A = 8'h20;
	localparam logic [7:0] TPC_REG_CUR_B = 8'h24;
	localparam logic [7:0] TPC_REG_ANGLE = 8'h28;
	localparam logic [7:0] TPC_REG_CYC_SIZE = 8'h2c;
	localparam logic [7:0] TPC_REG_CYC_DIV = 8'h30;
	localparam logic [7:0] TPC_REG_CUR_LIMIT = 8'h34;
	localparam logic [7:0] TPC_REG_DIRECT = 8'h38;
	localparam logic [7:0] TPC_REG_OPEN_LOOP = 8'h3c;
	localparam logic [7:0] TPC_REG_QUAD_CMD = 8'h40;
	localparam logic [7:0] TPC_REG_POSITION = 8'h44;
	localparam logic [7:0] TPC_REG_STATUS = 8'h48;
	// Field positions
	localparam int TPC_UPDATE_BIT = 0;
	localparam int TPC_OPEN_LOOP_EN_BIT = 16;
	localparam int TPC_ST_DIR_BIT = 0;
	localparam int TPC_ST_LOOP_BIT = 1;
	localparam int TPC_ST_PENDING_BIT = 2;
	// Reset values
	localparam logic [15:0] TPC_PERIOD_RST = 16'h0a2c;
	localparam logic [15:0] TPC_DEADTIME_RST = 16'h000f;
	localparam logic [7:0] TPC_ANGLE_RST = 8'h55;
	localparam logic [15:0] TPC_CYC_SIZE_RST = 16'h0800;
	localparam logic [15:0] TPC_CYC_DIV_RST = 16'h0001;
	localparam logic [15:0] TPC_CUR_LIMIT_RST = 16'h7fff;
	// Direction threshold of the commutation phase angle
	localparam logic [7:0] TPC_ANGLE_MID = 8'h80;
	// Carrier direction
	typedef enum logic [0:0] {TPC_UP = 1'b0, TPC_DOWN = 1'b1} tpc_dir_t;
endpackage

// >>> design/tpc_phase_leg.sv
// One phase leg: compare and deadtime for the high and low outputs
`timescale 1ns/1ps
module tpc_phase_leg
	import tpc_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] carrier_i,
	input wire logic [W-1:0] threshold_i,
	input wire logic [W-1:0] deadtime_i,
	output logic high_o,
	output logic low_o
);
	logic [W:0] hi_edge;
	logic [W:0] lo_edge;
	logic next_high;
	logic next_low;

	// High on while carrier is below threshold less half deadtime, low above plus half
	always_comb begin
		hi_edge = {1'b0, carrier_i} + {2'b00, deadtime_i[W-1:1]};
		lo_edge = {1'b0, carrier_i} - {2'b00, deadtime_i[W-1:1]} - {{W{1'b0}}, deadtime_i[0]};
		next_high = hi_edge < {1'b0, threshold_i};
		next_low = !lo_edge[W] && (lo_edge[W-1:0] >= threshold_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_o <= 1'b0;
			low_o <= 1'b0;
		end else begin
			high_o <= next_high; // RULE4 RULE5
			low_o <= next_low && !next_high; // RULE4
		end
	end

	pair_exclusive_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(high_o && low_o)) else $error("high and low on together"); // RULE4
endmodule

// >>> design/tpc_current_adjust.sv
// Offset correction of one 16-bit phase current reading
`timescale 1ns/1ps
module tpc_current_adjust
	import tpc_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] raw_i,
	input wire logic [W-1:0] offset_i,
	output logic [W-1:0] corrected_o
);
	logic signed [W:0] sum;
	logic [W-1:0] next_corrected;

	// Saturating signed add of the offset
	always_comb begin
		sum = $signed({raw_i[W-1], raw_i}) + $signed({offset_i[W-1], offset_i});
		if (sum[W] != sum[W-1]) begin
			next_corrected = sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end else begin
			next_corrected = sum[W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			corrected_o <= '0;
		end else begin
			corrected_o <= next_corrected; // RULE7 RULE8
		end
	end

	offset_applied_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(offset_i == '0 && $stable(raw_i)) |=> corrected_o == $past(raw_i))
		else $error("zero offset changed reading"); // RULE7
endmodule

// >>> dv/tpc_amp_model.sv
// Power-stage amplifier model: returns phase current readings to the PWM block
`timescale 1ns/1ps
module tpc_amp_model (
	input wire logic clk_i,
	input wire logic [2:0] high_i,
	input wire logic [2:0] low_i,
	input wire logic [15:0] bias_a_i,
	input wire logic [15:0] bias_b_i,
	output logic [15:0] adc_a_o,
	output logic [15:0] adc_b_o
);
	// Shoot-through in any leg saturates both readings
	always_ff @(posedge clk_i) begin
		if ((high_i & low_i) != 3'b000) begin
			adc_a_o <= 16'h8000;
			adc_b_o <= 16'h8000;
		end else begin
			adc_a_o <= bias_a_i;
			adc_b_o <= bias_b_i;
		end
	end
endmodule

// >>> dv/tpc_top_tb.sv
// Testbench of the three-phase PWM stage
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tpc_top_tb;
	import tpc_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fwd, closed;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd, dat_o;
	logic ack, same = 0, mon = 0;
	logic [15:0] fb = 16'h0, bias_a = 16'h0, bias_b = 16'h0, adc_a, adc_b;
	logic [2:0] hi, lo, hi_q = 3'b000, lo_q = 3'b000;
	int n_errors = 0, checks = 0, cyc_cnt = 0, dt = 10, P = 100;
	int since_lo[3] = '{1000, 1000, 1000}, since_hi[3] = '{1000, 1000, 1000};
	int hc[3], lc[3];
	logic [7:0] ra[6] = '{TPC_REG_PERIOD, TPC_REG_DEADTIME, TPC_REG_ANGLE, TPC_REG_CYC_SIZE,
		TPC_REG_CYC_DIV, TPC_REG_CUR_LIMIT};
	logic [15:0] rv[6] = '{TPC_PERIOD_RST, TPC_DEADTIME_RST, 16'h0055, TPC_CYC_SIZE_RST,
		TPC_CYC_DIV_RST, TPC_CUR_LIMIT_RST};
	logic [7:0] angs[5] = '{8'h7f, 8'h80, 8'h81, 8'h00, 8'hff};
	logic fexp[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	tpc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.phase_a_adc_i(adc_a), .phase_b_adc_i(adc_b), .feedback_count_i(fb),
		.phase_a_high_side_out_o(hi[0]), .phase_a_low_side_out_o(lo[0]),
		.phase_b_high_side_out_o(hi[1]), .phase_b_low_side_out_o(lo[1]),
		.phase_c_high_side_out_o(hi[2]), .phase_c_low_side_out_o(lo[2]),
		.commutation_forward_o(fwd), .current_loops_closed_o(closed));
	tpc_amp_model i_amp (.clk_i(clk_i), .high_i(hi), .low_i(lo), .bias_a_i(bias_a),
		.bias_b_i(bias_b), .adc_a_o(adc_a), .adc_b_o(adc_b));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	task final_report;
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask
	task meas;
		for (int i = 0; i < 3; i++) begin
			hc[i] = 0;
			lc[i] = 0;
		end
		repeat (2 * P) begin
			@(posedge clk_i);
			for (int i = 0; i < 3; i++) begin
				hc[i] += hi[i];
				lc[i] += lo[i];
			end
		end
	endtask
	function automatic logic near(int a, int b);
		return (a - b <= 2) && (b - a <= 2);
	endfunction
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt > 20000) begin
			n_errors++;
			final_report;
		end
	end
	// Per-leg gap counters and waveform watch
	always @(posedge clk_i) begin
		hi_q <= hi;
		lo_q <= lo;
		for (int i = 0; i < 3; i++) begin
			since_lo[i] <= lo[i] ? 0 : since_lo[i] + 1;
			since_hi[i] <= hi[i] ? 0 : since_hi[i] + 1;
			if (mon) begin
				`CHK("overlap", 1'b0, hi[i] & lo[i])
				if (hi[i] & ~hi_q[i]) `CHK("gap_lh", dt, since_lo[i])
				if (lo[i] & ~lo_q[i]) `CHK("gap_hl", dt, since_hi[i])
			end
		end
		if (same) begin
			`CHK("hi_phase", 1'b1, hi == 3'b000 || hi == 3'b111)
			`CHK("lo_phase", 1'b1, lo == 3'b000 || lo == 3'b111)
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) rdchk(ra[i], {16'h0, rv[i]}, "reset_val");
		rdchk(8'h4c, 32'h0, "unmapped");
		wb(1'b1, TPC_REG_PERIOD, P);
		wb(1'b1, TPC_REG_DEADTIME, dt);
		repeat (4 * P) @(posedge clk_i);
		same = 1;
		mon = 1;
		meas;
		for (int i = 0; i < 3; i++) begin
			`CHK("hi_on", 1'b1, near(hc[i], P - dt))
			`CHK("lo_on", 1'b1, near(lc[i], P - dt))
		end
		same = 0;
		wb(1'b1, TPC_REG_CMD_A, 32'd40);
		wb(1'b1, TPC_REG_CMD_B, 32'h0000ffd8);
		wb(1'b1, TPC_REG_CMD_C, 32'd0);
		meas;
		`CHK("a_shadow", 1'b1, near(hc[0], P - dt))
		wb(1'b1, TPC_REG_UPDATE, 32'h1);
		repeat (2 * P) @(posedge clk_i);
		meas;
		`CHK("a_hi", 1'b1, near(hc[0], P - dt + 40))
		`CHK("a_lo", 1'b1, near(lc[0], P - dt - 40))
		`CHK("b_hi", 1'b1, near(hc[1], P - dt - 40))
		`CHK("b_lo", 1'b1, near(lc[1], P - dt + 40))
		`CHK("c_hi", 1'b1, near(hc[2], P - dt))
		wb(1'b1, TPC_REG_CMD_A, 32'd0);
		wb(1'b1, TPC_REG_CMD_B, 32'd0);
		wb(1'b1, TPC_REG_UPDATE, 32'h1);
		repeat (3 * P) @(posedge clk_i);
		same = 1;
		bias_a <= 16'h0123;
		bias_b <= 16'hffb0;
		wb(1'b1, TPC_REG_OFFSET_A, 32'h0000fedd);
		wb(1'b1, TPC_REG_OFFSET_B, 32'h00000050);
		repeat (8) @(posedge clk_i);
		rdchk(TPC_REG_CUR_A, 32'h0, "cur_a");
		rdchk(TPC_REG_CUR_B, 32'h0, "cur_b");
		wb(1'b1, TPC_REG_OFFSET_A, 32'h00000010);
		repeat (8) @(posedge clk_i);
		rdchk(TPC_REG_CUR_A, 32'h00000133, "cur_a");
		rdchk(TPC_REG_CUR_B, 32'h0, "cur_b");
		bias_a <= 16'h7ff0;
		wb(1'b1, TPC_REG_OFFSET_A, 32'h00000100);
		repeat (8) @(posedge clk_i);
		rdchk(TPC_REG_CUR_A, 32'h00007fff, "cur_sat");
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, TPC_REG_ANGLE, {24'h0, angs[i]});
			repeat (2) @(posedge clk_i);
			`CHK("forward", fexp[i], fwd)
			wb(1'b0, TPC_REG_STATUS, 32'h0);
			`CHK("st_dir", fexp[i], rd[TPC_ST_DIR_BIT])
		end
		fb <= 16'h1234;
		wb(1'b1, TPC_REG_CYC_SIZE, 32'h00001002);
		wb(1'b1, TPC_REG_CYC_DIV, 32'h2);
		repeat (4) @(posedge clk_i);
		rdchk(TPC_REG_POSITION, 32'h08011234, "position");
		wb(1'b1, TPC_REG_CYC_DIV, 32'h0);
		rdchk(TPC_REG_CYC_DIV, 32'h1, "div_zero");
		wb(1'b1, TPC_REG_CUR_LIMIT, 32'h00001000);
		wb(1'b1, TPC_REG_OPEN_LOOP, 32'h00010032);
		repeat (2) @(posedge clk_i);
		`CHK("loops", 1'b1, closed)
		rdchk(TPC_REG_QUAD_CMD, 32'h00000800, "quad");
		wb(1'b1, TPC_REG_DIRECT, 32'h00000bb8);
		rdchk(TPC_REG_DIRECT, 32'h00000bb8, "direct");
		rdchk(TPC_REG_QUAD_CMD, 32'h00000800, "quad");
		wb(1'b1, TPC_REG_OPEN_LOOP, 32'h0);
		repeat (2) @(posedge clk_i);
		`CHK("loops", 1'b0, closed)
		final_report;
	end
endmodule
